// *** rtl/ast_defines.svh ***
/*
  Named constants for the scan trigger and completion request logic.
  Assumes inclusion by bare name from the package and design modules.
*/
`ifndef AST_DEFINES_SVH
`define AST_DEFINES_SVH

// Number of converter units served.
`define AST_UNITS     3
// Group codes carried on the scan group outputs.
`define AST_GRP_A     2'h0
`define AST_GRP_B     2'h1
`define AST_GRP_C     2'h2
// Trigger source select codes for each group.
`define AST_SEL_MTU   2'h0
`define AST_SEL_PWM   2'h1
`define AST_SEL_BYTE  2'h2
`define AST_SEL_EXT   2'h3
// Level of an external start pin while it is idle.
`define AST_PIN_IDLE  1'h1
// Field widths.
`define AST_GRP_W     2
`define AST_SEL_W     2

`endif

// *** rtl/ast_pkg.sv ***
/*
  Types shared by the scan trigger logic.
  Assumes ast_defines.svh is on the include path.
*/
`include "ast_defines.svh"

package ast_pkg;

  // One-hot scan sequencer states.
  typedef enum logic [1:0] {
    AST_ST_IDLE = 2'h1,
    AST_ST_BUSY = 2'h2
  } ast_state_t;

endpackage : ast_pkg

// *** rtl/ast_sync3.sv ***
/*
  Three-stage synchroniser for one asynchronous pin.
  Assumes a single clock i_clk and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ast_defines.svh"

module ast_sync3 (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_d,
  output var  logic o_q
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_r <= `AST_PIN_IDLE;
      s2_r <= `AST_PIN_IDLE;
      s3_r <= `AST_PIN_IDLE;
    end else begin
      s1_r <= i_d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // The output follows only once the second and third stages agree.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_q <= `AST_PIN_IDLE;
    end else if (s2_r == s3_r) begin
      o_q <= s3_r;
    end
  end

endmodule : ast_sync3
`default_nettype wire

// *** rtl/ast_top.sv ***
/*
  Scan start selection and scan completion requests for three converter units.
  Assumes the analog core reports a finished group scan on i_conv_done and
  that timer triggers are one-cycle pulses on i_clk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ast_defines.svh"

module ast_top
  import ast_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [2:0]  i_sw_start,
  input  wire logic        i_mtu_trg,
  input  wire logic        i_pwm_trg,
  input  wire logic        i_byte_trg,
  input  wire logic [2:0]  i_ext_start_pin_n,
  input  wire logic [2:0]  i_mode_double,
  input  wire logic [2:0]  i_mode_group,
  input  wire logic [2:0]  i_three_groups,
  input  wire logic [2:0]  i_grp_prio,
  input  wire logic [5:0]  i_trg_sel_a,
  input  wire logic [5:0]  i_trg_sel_b,
  input  wire logic [5:0]  i_trg_sel_c,
  input  wire logic [2:0]  i_conv_done,
  output var  logic [2:0]  o_scan_start,
  output var  logic [2:0]  o_scan_abort,
  output var  logic [5:0]  o_scan_grp,
  output var  logic [2:0]  o_scan_end_req,
  output var  logic [2:0]  o_group_b_end_req,
  output var  logic [2:0]  o_group_c_end_req
);

  // Selects the trigger pulse named by a source select code.
  function automatic logic trig_hit(input logic [`AST_SEL_W-1:0] sel,
                                    input logic mtu, input logic pwm,
                                    input logic byt, input logic ext);
    case (sel)
      `AST_SEL_MTU:  trig_hit = mtu;
      `AST_SEL_PWM:  trig_hit = pwm;
      `AST_SEL_BYTE: trig_hit = byt;
      default:       trig_hit = ext;
    endcase
  endfunction : trig_hit

  // Picks the highest-priority group among the requests, A first.
  function automatic logic [`AST_GRP_W-1:0] pick_grp(input logic [2:0] req);
    if (req[0]) begin
      pick_grp = `AST_GRP_A;
    end else if (req[1]) begin
      pick_grp = `AST_GRP_B;
    end else begin
      pick_grp = `AST_GRP_C;
    end
  endfunction : pick_grp

  genvar u;
  generate
    for (u = 0; u < `AST_UNITS; u = u + 1) begin : g_unit
      ast_state_t              state_r;
      logic [`AST_GRP_W-1:0]   grp_r;
      logic [2:0]              pend_r;
      logic [2:0]              dbl_r;
      logic                    ext_q;
      logic                    ext_prev_r;
      logic                    ext_fall;
      logic [2:0]              trg;
      logic [2:0]              req;
      logic [`AST_GRP_W-1:0]   next_grp;
      logic                    idle;
      logic                    busy;
      logic                    done;
      logic                    abort;
      logic                    fire;
      logic                    start_r;
      logic                    abort_r;
      logic                    end_a_r;
      logic                    end_b_r;
      logic                    end_c_r;

      // Each unit samples only its own external start pin.
      ast_sync3 u_sync (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_d   (i_ext_start_pin_n[u]),
        .o_q   (ext_q)
      );

      // Detects the falling edge of the synchronised pin.
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          ext_prev_r <= `AST_PIN_IDLE;
        end else begin
          ext_prev_r <= ext_q;
        end
      end
      assign ext_fall = ext_prev_r & ~ext_q;

      // Group triggers; software always starts group A.
      assign trg[0] = i_sw_start[u]
                    | trig_hit(i_trg_sel_a[`AST_SEL_W*u +: `AST_SEL_W], i_mtu_trg, i_pwm_trg,
                               i_byte_trg, ext_fall);
      assign trg[1] = i_mode_group[u]
                    & trig_hit(i_trg_sel_b[`AST_SEL_W*u +: `AST_SEL_W], i_mtu_trg, i_pwm_trg,
                               i_byte_trg, ext_fall);
      assign trg[2] = i_mode_group[u] & i_three_groups[u]
                    & trig_hit(i_trg_sel_c[`AST_SEL_W*u +: `AST_SEL_W], i_mtu_trg, i_pwm_trg,
                               i_byte_trg, ext_fall);
      assign req      = pend_r | trg;
      assign next_grp = pick_grp(req);
      assign idle     = (state_r == AST_ST_IDLE);
      assign busy     = (state_r == AST_ST_BUSY);
      assign done     = busy & i_conv_done[u];
      // A higher group trigger preempts a running lower group scan.
      assign abort    = busy & i_grp_prio[u] & ~i_conv_done[u]
                      & (|req) & (next_grp < grp_r);
      // In double mode only the second completion of a group fires.
      assign fire     = done & (~i_mode_double[u] | dbl_r[grp_r]);

      // Scan sequencer: starts, aborts and finishes group scans.
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          state_r <= AST_ST_IDLE;
          grp_r   <= `AST_GRP_A;
        end else begin
          case (state_r)
            AST_ST_IDLE: begin
              if (|req) begin
                state_r <= AST_ST_BUSY;
                grp_r   <= next_grp;
              end
            end
            AST_ST_BUSY: begin
              if (abort) begin
                grp_r <= next_grp;
              end else if (done) begin
                state_r <= AST_ST_IDLE;
              end
            end
            default: begin
              state_r <= AST_ST_IDLE;
              grp_r   <= `AST_GRP_A;
            end
          endcase
        end
      end

      // Triggers that cannot start at once wait; the started group clears.
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          pend_r <= 3'h0;
        end else if ((idle & (|req)) | abort) begin
          pend_r <= req & ~(3'h1 << next_grp);
        end else begin
          pend_r <= req;
        end
      end

      // Counts the first and second completion of each group in double mode.
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          dbl_r <= 3'h0;
        end else if (done & i_mode_double[u]) begin
          dbl_r[grp_r] <= ~dbl_r[grp_r];
        end
      end

      // Start, abort and completion pulses, each lasting one cycle.
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          start_r <= 1'h0;
          abort_r <= 1'h0;
          end_a_r <= 1'h0;
          end_b_r <= 1'h0;
          end_c_r <= 1'h0;
        end else begin
          start_r <= (idle & (|req)) | abort;
          abort_r <= abort;
          end_a_r <= fire & (grp_r == `AST_GRP_A);
          end_b_r <= fire & (grp_r == `AST_GRP_B);
          end_c_r <= fire & (grp_r == `AST_GRP_C);
        end
      end

      // Requests go out unchanged to interrupt and transfer controllers.
      assign o_scan_start[u]      = start_r;
      assign o_scan_abort[u]      = abort_r;
      assign o_scan_grp[`AST_GRP_W*u +: `AST_GRP_W] = grp_r;
      assign o_scan_end_req[u]    = end_a_r;
      assign o_group_b_end_req[u] = end_b_r;
      assign o_group_c_end_req[u] = end_c_r;

      sw_start_a: assert property (@(posedge i_clk) disable iff (i_rst)
        idle & i_sw_start[u] |=> o_scan_start[u] && grp_r == `AST_GRP_A)
        else $error("Software start did not begin a group A scan.");

      timer_trig_a: assert property (@(posedge i_clk) disable iff (i_rst)
        idle & i_mtu_trg & (i_trg_sel_a[`AST_SEL_W*u +: `AST_SEL_W] == `AST_SEL_MTU)
          |=> o_scan_start[u])
        else $error("Timer trigger did not start a scan.");

      ext_pin_a: assert property (@(posedge i_clk) disable iff (i_rst)
        idle & ext_fall & (i_trg_sel_a[`AST_SEL_W*u +: `AST_SEL_W] == `AST_SEL_EXT)
          |=> o_scan_start[u])
        else $error("External pin edge did not start a scan.");

      single_end_a: assert property (@(posedge i_clk) disable iff (i_rst)
        done & ~i_mode_double[u] & ~i_mode_group[u] |=> o_scan_end_req[u])
        else $error("Single scan end gave no scan end request.");

      double_first_a: assert property (@(posedge i_clk) disable iff (i_rst)
        done & i_mode_double[u] & ~dbl_r[grp_r] |=> ~o_scan_end_req[u]
          && ~o_group_b_end_req[u] && ~o_group_c_end_req[u])
        else $error("Request raised after first scan of a double scan.");

      group_b_end_a: assert property (@(posedge i_clk) disable iff (i_rst)
        done & ~i_mode_double[u] & (grp_r == `AST_GRP_B)
          |=> o_group_b_end_req[u] && ~o_scan_end_req[u])
        else $error("Group B end did not raise its own request.");

      group_c_end_a: assert property (@(posedge i_clk) disable iff (i_rst)
        done & ~i_mode_double[u] & (grp_r == `AST_GRP_C) |=> o_group_c_end_req[u])
        else $error("Group C end did not raise its own request.");

      end_pulse_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_scan_end_req[u] |=> ~o_scan_end_req[u])
        else $error("Scan end request lasted more than one cycle.");

      prio_abort_a: assert property (@(posedge i_clk) disable iff (i_rst)
        busy & i_grp_prio[u] & ~i_conv_done[u] & (grp_r == `AST_GRP_B) & trg[0]
          |=> o_scan_abort[u] && o_scan_start[u] && grp_r == `AST_GRP_A)
        else $error("Group A trigger did not preempt group B scan.");
    end
  endgenerate

endmodule : ast_top
`default_nettype wire

// *** testbench/ast_core_model.sv ***
/*
  Behavioural analog core that answers the latest scan start of each unit with a done pulse.
  Assumes scan starts are one-cycle pulses on i_clk and a latency of two or more.
*/
`timescale 1ns/1ns
`default_nettype none

module ast_core_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [2:0] i_start,
  input  wire logic [7:0] i_lat,
  output var  logic [2:0] o_done
);
  logic [7:0] cnt_r [3];

  initial o_done = 3'h0;

  // A start, whether it preempts or not, reloads that unit's countdown.
  always @(negedge i_clk) begin
    for (int u = 0; u < 3; u++) begin
      o_done[u] <= 1'h0;
      if (i_rst) cnt_r[u] <= 8'h00;
      else if (i_start[u]) cnt_r[u] <= i_lat;
      else if (cnt_r[u] == 8'h01) begin
        cnt_r[u]  <= 8'h00;
        o_done[u] <= 1'h1;
      end else if (cnt_r[u] != 8'h00) cnt_r[u] <= cnt_r[u] - 8'h01;
    end
  end
endmodule : ast_core_model
`default_nettype wire

// *** testbench/ast_top_tb_top.sv ***
/*
  Self-checking bench that fires triggers and counts completion pulses.
  Assumes ast_top and the behavioural core model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module ast_top_tb_top;
  logic       i_clk = 1'h0, i_rst = 1'h1, mtu = 1'h0, pwm = 1'h0, byt = 1'h0;
  logic [2:0] sw = 3'h0, pin_n = 3'h7, dbl = 3'h0, grp = 3'h0, thr = 3'h0, pri = 3'h0;
  logic [5:0] sa = 6'h00, sb = 6'h00, sc = 6'h00, sgrp;
  logic [2:0] st, ab, er, br, cr, done, m, er_q, br_q, cr_q;
  logic [7:0] lat = 8'h04;
  logic [7:0] c_end [3], c_b [3], c_c [3], c_ab [3];
  int         n_mismatch = 0, n_compared = 0, seed = 43375;

  always #50 i_clk = ~i_clk;

  ast_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_sw_start(sw), .i_mtu_trg(mtu),
    .i_pwm_trg(pwm), .i_byte_trg(byt), .i_ext_start_pin_n(pin_n), .i_mode_double(dbl),
    .i_mode_group(grp), .i_three_groups(thr), .i_grp_prio(pri), .i_trg_sel_a(sa),
    .i_trg_sel_b(sb), .i_trg_sel_c(sc), .i_conv_done(done), .o_scan_start(st),
    .o_scan_abort(ab), .o_scan_grp(sgrp), .o_scan_end_req(er),
    .o_group_b_end_req(br), .o_group_c_end_req(cr));

  ast_core_model core (.i_clk(i_clk), .i_rst(i_rst), .i_start(st), .i_lat(lat),
    .o_done(done));

  task automatic chk(input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk

  function automatic logic [23:0] cnt3(input logic [2:0] v);
    return {7'h00, v[2], 7'h00, v[1], 7'h00, v[0]};
  endfunction : cnt3

  // Units whose group A select equals the given trigger code.
  function automatic logic [2:0] hits(input logic [5:0] s, input logic [1:0] k);
    for (int u = 0; u < 3; u++) hits[u] = (s[2*u+:2] == k);
  endfunction : hits

  // Counts pulses; the same request high on two samples in a row is too wide.
  always @(negedge i_clk) begin
    for (int u = 0; u < 3; u++) begin
      c_end[u] <= c_end[u] + {7'h00, er[u]};
      c_b[u]   <= c_b[u] + {7'h00, br[u]};
      c_c[u]   <= c_c[u] + {7'h00, cr[u]};
      c_ab[u]  <= c_ab[u] + {7'h00, ab[u]};
    end
    if (!i_rst) chk(24'h0, {21'h0, (er & er_q) | (br & br_q) | (cr & cr_q)});
    {er_q, br_q, cr_q} <= {er, br, cr};
  end

  // Clears counters on a rising edge, then returns at a falling edge with a new latency.
  task automatic clr();
    @(posedge i_clk);
    for (int u = 0; u < 3; u++) {c_end[u], c_b[u], c_c[u], c_ab[u]} = 32'h0;
    lat = 8'h02 + 8'($unsigned($random(seed)) % 8);
    @(negedge i_clk);
  endtask : clr

  // Kind 0 software, 1 to 3 timers, 4 external pins; v picks units for 0 and 4.
  task automatic fire(input int k, input logic [2:0] v, input int w);
    @(negedge i_clk);
    if (k == 0) sw = v;
    mtu = (k == 1);
    pwm = (k == 2);
    byt = (k == 3);
    if (k == 4) pin_n = ~v;
    @(negedge i_clk);
    {sw, mtu, pwm, byt} = 6'h00;
    repeat (6) @(negedge i_clk);
    pin_n = 3'h7;
    repeat (w) @(negedge i_clk);
  endtask : fire

  task automatic expect3(input logic [2:0] e, input logic [2:0] b, input logic [2:0] c);
    chk(cnt3(e), {c_end[2], c_end[1], c_end[0]});
    chk(cnt3(b), {c_b[2], c_b[1], c_b[0]});
    chk(cnt3(c), {c_c[2], c_c[1], c_c[0]});
  endtask : expect3

  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test

  // Main sequence of scenarios.
  initial begin
    repeat (12) @(negedge i_clk);
    i_rst = 1'h0;
    repeat (4) @(negedge i_clk);
    clr();
    m = 3'h1 << ($unsigned($random(seed)) % 3);
    fire(0, m, 30);
    expect3(m, 3'h0, 3'h0);
    $display("software start test done");
    for (int k = 0; k < 3; k++) begin
      clr();
      for (int u = 0; u < 3; u++) sa[2*u+:2] = 2'($unsigned($random(seed)) % 3);
      // Unit 0 always listens to the timer under test, as a fixed corner.
      sa[1:0] = 2'(k);
      fire(k + 1, 3'h0, 30);
      expect3(hits(sa, 2'(k)), 3'h0, 3'h0);
    end
    $display("timer trigger test done");
    sa = 6'h3F;
    for (int u = 0; u < 3; u++) begin
      clr();
      fire(4, 3'h1 << u, 30);
      expect3(3'h1 << u, 3'h0, 3'h0);
    end
    $display("external pin test done");
    dbl = 3'h7;
    clr();
    fire(0, 3'h7, 30);
    expect3(3'h0, 3'h0, 3'h0);
    fire(0, 3'h7, 30);
    expect3(3'h7, 3'h0, 3'h0);
    $display("double trigger test done");
    // Group A moves to the byte timer, so timer pulses aimed at B or C leave A alone.
    {dbl, grp, sa, sb, sc} = {3'h0, 3'h7, 6'h2A, 6'h00, 6'h15};
    clr();
    fire(2, 3'h0, 30);
    expect3(3'h0, 3'h0, 3'h0);
    thr = 3'h7;
    fire(1, 3'h0, 30);
    fire(2, 3'h0, 30);
    chk({18'h0, 6'h2A}, {18'h0, sgrp});
    fire(0, 3'h7, 30);
    expect3(3'h7, 3'h7, 3'h7);
    $display("group scan test done");
    dbl = 3'h7;
    clr();
    for (int i = 0; i < 2; i++) begin
      fire(1, 3'h0, 30);
      fire(2, 3'h0, 30);
      fire(0, 3'h7, 30);
      expect3({3{i == 1}}, {3{i == 1}}, {3{i == 1}});
    end
    $display("double group test done");
    {dbl, pri} = {3'h0, 3'h7};
    clr();
    lat = 8'h28;
    fire(1, 3'h0, 4);
    chk({18'h0, 6'h15}, {18'h0, sgrp});
    fire(0, 3'h7, 80);
    chk(24'h0, {18'h0, sgrp});
    expect3(3'h7, 3'h0, 3'h0);
    chk(cnt3(3'h7), {c_ab[2], c_ab[1], c_ab[0]});
    $display("priority test done");
    end_of_test();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #(100 * 5000);
    n_mismatch++;
    end_of_test();
  end
endmodule : ast_top_tb_top
`default_nettype wire
